// ==== src/vdo_output_ctrl.sv ====
// format status, vbi code selection and output pin control of the video decoder
`timescale 1ns/10ps
`include "vdo_defines.svh"
module vdo_output_ctrl
  import vdo_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h2a
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // serial register port
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // format detector
  input wire vdo_fmt_t det_fmt,
  input wire logic det_locked,
  input wire logic colour_kill_en,
  output vdo_fmt_t active_fmt,
  // pixel stream from the decoder core
  input wire logic [7:0] pix_code,
  input wire logic pix_is_luma,
  input wire logic [9:0] line_num,
  input wire logic line_second_half,
  input wire vdo_vid_t sync_in,
  // output pins
  input wire logic power_down_pin_n,
  output logic pixel_clock_out,
  output vdo_vid_t vid_out,
  output logic vflag_out,
  output logic pins_oe_n
);
  logic [7:0] fmt_reg_q, cand_q, vbi_q, tcs_q, slh_q, sll_q, stat_q, rd_data;
  logic [4:0] pin_q;
  logic wr_en;
  logic [7:0] wr_addr, wr_data, rd_addr;
  logic [2:0] pdn_r;
  logic run_q, pclk_q, vflag_q;
  logic [7:0] code_q, last_y_q, code_d, sel_d;
  vdo_vid_t sync_q;
  logic [7:0] stat_d;
  logic excl;
  logic [10:0] h;
  logic [2:0] win;
  logic [9:0] d10;
  logic is625, in_win, vflag_d, early;
  logic [7:0] thr, slice_y;

  function automatic logic hr(input logic [10:0] hv, input logic [9:0] lo, input logic lh,
                              input logic [9:0] hi, input logic hh);
    hr = (hv >= {lo, lh}) && (hv <= {hi, hh});
  endfunction : hr

  // ----------------------------------------
  // register port and register file
  // ----------------------------------------
  vdo_i2c_slave #(
    .DEV_ADDR(DEV_ADDR)
  ) u_i2c (
    .core_clk(core_clk),
    .rst(rst),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_oe_n(sda_oe_n),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fmt_reg_q <= `VDO_RST_ZERO;
      cand_q <= `VDO_RST_ZERO;
      vbi_q <= `VDO_RST_ZERO;
      pin_q <= `VDO_RST_PIN;
      tcs_q <= `VDO_RST_ZERO;
      slh_q <= `VDO_RST_SLH;
      sll_q <= `VDO_RST_SLL;
      sda_out <= 1'b0;
    end else if (wr_en) begin
      case (wr_addr)
        `VDO_REG_FMT: fmt_reg_q <= wr_data;
        `VDO_REG_CAND: cand_q <= wr_data;
        `VDO_REG_VBI: vbi_q <= wr_data;
        `VDO_REG_PIN: pin_q <= wr_data[`VDO_PIN_HI:0];
        `VDO_REG_TCS: tcs_q <= wr_data;
        `VDO_REG_SLH: slh_q <= wr_data;
        `VDO_REG_SLL: sll_q <= wr_data;
        default: pin_q <= pin_q;
      endcase
    end
  end

  always_comb begin
    case (rd_addr)
      `VDO_REG_FMT: rd_data = fmt_reg_q;
      `VDO_REG_CAND: rd_data = cand_q;
      `VDO_REG_VBI: rd_data = vbi_q;
      `VDO_REG_PIN: rd_data = {3'h0, pin_q};
      `VDO_REG_TCS: rd_data = tcs_q;
      `VDO_REG_SLH: rd_data = slh_q;
      `VDO_REG_SLL: rd_data = sll_q;
      `VDO_REG_STAT: rd_data = stat_q;
      default: rd_data = 8'h00;
    endcase
  end

  // ----------------------------------------
  // format detection status
  // ----------------------------------------
  always_comb begin
    excl = (cand_q[`VDO_X_PALM] & ~det_fmt.lines625 & (det_fmt.colour == 2'h1) & (det_fmt.subc == 2'h1))
         | (cand_q[`VDO_X_PALNC] & det_fmt.lines625 & (det_fmt.colour == 2'h1) & (det_fmt.subc == 2'h2))
         | (cand_q[`VDO_X_SECAM] & (det_fmt.colour == 2'h2))
         | (cand_q[`VDO_X_N443] & ~det_fmt.lines625 & (det_fmt.colour == 2'h0) & (det_fmt.subc == 2'h3))
         | (cand_q[`VDO_X_PAL60] & ~det_fmt.lines625 & (det_fmt.colour == 2'h1) & (det_fmt.subc == 2'h3))
         | (cand_q[`VDO_X_525] & ~det_fmt.lines625)
         | (cand_q[`VDO_X_625] & det_fmt.lines625);
    if (fmt_reg_q[`VDO_AUTO_BIT]) begin
      // detected fields pass through as read, mono gated by colour_kill_en; excluded candidates or colour code 3 set bit 6
      stat_d = {det_locked, excl | (det_fmt.colour == 2'h3), colour_kill_en & det_fmt.mono,
                det_fmt.lines625, det_fmt.colour, det_fmt.subc};
    end else begin
      stat_d = {det_locked, 1'b0, fmt_reg_q[5:0]};
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stat_q <= `VDO_RST_ZERO;
      active_fmt <= '0;
    end else begin
      stat_q <= stat_d;
      active_fmt <= stat_d[5:0];
    end
  end

  // ----------------------------------------
  // line position decoding
  // ----------------------------------------
  always_comb begin
    h = {line_num, line_second_half};
    is625 = stat_q[4];
    win = (vbi_q[`VDO_WIN_HI:0] == 3'h4) ? 3'h0 : vbi_q[`VDO_WIN_HI:0];
    d10 = {{7{win[2]}}, win};
    if (is625) begin
      in_win = hr(h, `VDO_L_623, 1'h1, `VDO_L_625, 1'h1) | hr(h, `VDO_L_FIRST, 1'h0, `VDO_L_23 + d10, 1'h0)
             | hr(h, `VDO_L_311, 1'h0, `VDO_L_335 + d10, 1'h1);
      vflag_d = hr(h, `VDO_L_FIRST, 1'h0, `VDO_L_22, 1'h1) | hr(h, `VDO_L_311, 1'h0, `VDO_L_335, 1'h1)
              | hr(h, `VDO_L_624, 1'h0, `VDO_L_625, 1'h1);
      early = hr(h, `VDO_L_623, 1'h1, `VDO_L_625, 1'h1) | hr(h, `VDO_L_FIRST, 1'h0, `VDO_L_6, 1'h0)
            | hr(h, `VDO_L_311, 1'h0, `VDO_L_318, 1'h1);
    end else begin
      in_win = hr(h, `VDO_L_FIRST, 1'h0, `VDO_L_19 + d10, 1'h1)
             | hr(h, `VDO_L_263, 1'h1, `VDO_L_282 + d10, 1'h0);
      if (vbi_q[`VDO_VSEL_BIT]) begin
        vflag_d = hr(h, `VDO_L_FIRST, 1'h0, `VDO_L_19, 1'h1) | hr(h, `VDO_L_264, 1'h0, `VDO_L_282, 1'h1);
      end else begin
        vflag_d = hr(h, `VDO_L_FIRST, 1'h0, `VDO_L_9, 1'h1) | hr(h, `VDO_L_264, 1'h0, `VDO_L_272, 1'h1);
      end
      early = hr(h, `VDO_L_FIRST, 1'h0, `VDO_L_9, 1'h1) | hr(h, `VDO_L_263, 1'h1, `VDO_L_272, 1'h0);
    end
  end

  // ----------------------------------------
  // output code selection and range
  // ----------------------------------------
  always_comb begin
    thr = vbi_q[`VDO_SLICE_THRESHOLD_SELECT_BIT] ? `VDO_THR_50 : `VDO_THR_25;
    slice_y = (pix_code > thr) ? slh_q : sll_q;
    sel_d = pix_code;
    if (early) begin
      sel_d = pix_is_luma ? `VDO_BLACK_Y : `VDO_MID_C;
    end else if (in_win) begin
      case (vdo_vdec_t'(vbi_q[`VDO_VDEC_HI:`VDO_VDEC_LO]))
        VDO_V_MONO: sel_d = pix_is_luma ? pix_code : `VDO_MID_C;
        VDO_V_SLICE: sel_d = pix_is_luma ? slice_y : last_y_q;
        default: sel_d = pix_is_luma ? `VDO_BLACK_Y : `VDO_MID_C;
      endcase
    end
    code_d = sel_d;
    if (vbi_q[`VDO_LIMIT_BIT]) begin
      if (sel_d < `VDO_LIM_MIN) code_d = `VDO_LIM_MIN;
      else if (pix_is_luma && sel_d > `VDO_LIM_Y_MAX) code_d = `VDO_LIM_Y_MAX;
      else if (!pix_is_luma && sel_d > `VDO_LIM_C_MAX) code_d = `VDO_LIM_C_MAX;
    end else if (!tcs_q[`VDO_TCS_BIT]) begin
      if (sel_d < `VDO_INT_MIN) code_d = `VDO_INT_MIN;
      else if (sel_d > `VDO_INT_MAX) code_d = `VDO_INT_MAX;
    end
  end

  // ----------------------------------------
  // pixel rate stage
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pclk_q <= 1'b0;
      code_q <= `VDO_BLACK_Y;
      last_y_q <= `VDO_BLACK_Y;
      sync_q <= '0;
      vflag_q <= 1'b0;
    end else begin
      pclk_q <= ~pclk_q;
      if (pclk_q) begin
        code_q <= code_d;
        sync_q <= sync_in;
        vflag_q <= vflag_d;
        if (pix_is_luma) last_y_q <= code_d;
      end
    end
  end

  // ----------------------------------------
  // power-down pin and pin drivers
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pdn_r <= 3'h7;
      run_q <= 1'b1;
    end else begin
      pdn_r <= {pdn_r[1:0], power_down_pin_n};
      if (pdn_r[1] == pdn_r[2]) run_q <= pdn_r[2];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pixel_clock_out <= 1'b0;
      vid_out <= '0;
      vflag_out <= 1'b0;
      pins_oe_n <= 1'b0;
    end else if (!run_q) begin
      pixel_clock_out <= 1'b0;
      vid_out <= '0;
      vflag_out <= 1'b0;
      pins_oe_n <= 1'b0;
    end else begin
      pins_oe_n <= pin_q[`VDO_OEN_BIT];
      // clock rises with the code update so data changes on the falling half
      pixel_clock_out <= pclk_q;
      vflag_out <= vflag_q;
      vid_out.data <= pin_q[`VDO_DL_BIT] ? 8'h00 : code_q;
      vid_out.vsync <= sync_q.vsync & ~pin_q[`VDO_VDL_BIT];
      vid_out.aux <= sync_q.aux & ~pin_q[`VDO_AUXL_BIT];
      vid_out.hsync <= sync_q.hsync & ~pin_q[`VDO_HL_BIT];
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_pd_all_low: assert property (@(posedge core_clk) disable iff (rst)
    !run_q |=> (vid_out == '0 && !pixel_clock_out && !pins_oe_n))
    else $error("power down did not pull outputs low");
  a_tristate_wins: assert property (@(posedge core_clk) disable iff (rst)
    (run_q && pin_q[`VDO_OEN_BIT]) |=> pins_oe_n)
    else $error("tristate bit did not release the pins");
  a_force_low_data: assert property (@(posedge core_clk) disable iff (rst)
    (run_q && pin_q[`VDO_DL_BIT]) ##1 pin_q[`VDO_DL_BIT] |-> vid_out.data == 8'h00)
    else $error("data not forced low");
  a_limit_range: assert property (@(posedge core_clk) disable iff (rst)
    (pclk_q && vbi_q[`VDO_LIMIT_BIT]) |=> (code_q >= `VDO_LIM_MIN && code_q <= `VDO_LIM_C_MAX))
    else $error("limited code out of range");
  a_internal_range: assert property (@(posedge core_clk) disable iff (rst)
    (pclk_q && !tcs_q[`VDO_TCS_BIT]) |=> (code_q >= `VDO_INT_MIN && code_q <= `VDO_INT_MAX))
    else $error("code outside internal range");
  a_mono_kill: assert property (@(posedge core_clk) disable iff (rst)
    (fmt_reg_q[`VDO_AUTO_BIT] && !colour_kill_en) |=> !stat_q[5])
    else $error("mono reported without colour kill");
  a_exclude_lines: assert property (@(posedge core_clk) disable iff (rst)
    (fmt_reg_q[`VDO_AUTO_BIT] && ((cand_q[`VDO_X_525] && !det_fmt.lines625) ||
      (cand_q[`VDO_X_625] && det_fmt.lines625))) |=> stat_q[6])
    else $error("excluded line count not flagged");
  a_early_black: assert property (@(posedge core_clk) disable iff (rst)
    (pclk_q && early && pix_is_luma && run_q && !pin_q[`VDO_DL_BIT]) ##1 (run_q && !pin_q[`VDO_DL_BIT])
      |=> vid_out.data == `VDO_BLACK_Y)
    else $error("early line not black");
  a_vflag_525: assert property (@(posedge core_clk) disable iff (rst)
    (pclk_q && !is625 && line_num == `VDO_L_9 && run_q) ##1 run_q |=> vflag_out)
    else $error("v flag low on line nine");
endmodule : vdo_output_ctrl

// ==== src/vdo_defines.svh ====
// register map, field positions, reset values and code constants of the video output control block
`ifndef VDO_DEFINES_SVH
`define VDO_DEFINES_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define VDO_REG_FMT 8'h02
`define VDO_REG_CAND 8'h03
`define VDO_REG_VBI 8'h04
`define VDO_REG_PIN 8'h05
`define VDO_REG_TCS 8'h08
`define VDO_REG_SLH 8'h11
`define VDO_REG_SLL 8'h12
`define VDO_REG_STAT 8'h18
// ----------------------------------------
// field positions
// ----------------------------------------
`define VDO_AUTO_BIT 7
`define VDO_LIMIT_BIT 3
`define VDO_VSEL_BIT 4
`define VDO_SLICE_THRESHOLD_SELECT_BIT 5
`define VDO_VDEC_HI 7
`define VDO_VDEC_LO 6
`define VDO_WIN_HI 2
`define VDO_DL_BIT 0
`define VDO_VDL_BIT 1
`define VDO_AUXL_BIT 2
`define VDO_HL_BIT 3
`define VDO_OEN_BIT 4
`define VDO_PIN_HI 4
`define VDO_TCS_BIT 2
`define VDO_X_PALM 0
`define VDO_X_PALNC 1
`define VDO_X_SECAM 2
`define VDO_X_N443 4
`define VDO_X_PAL60 5
`define VDO_X_525 6
`define VDO_X_625 7
// ----------------------------------------
// reset values
// ----------------------------------------
`define VDO_RST_ZERO 8'h00
`define VDO_RST_PIN 5'h0f
`define VDO_RST_SLH 8'heb
`define VDO_RST_SLL 8'h10
// ----------------------------------------
// output codes and slice thresholds
// ----------------------------------------
`define VDO_BLACK_Y 8'h10
`define VDO_MID_C 8'h80
`define VDO_LIM_MIN 8'h10
`define VDO_LIM_Y_MAX 8'heb
`define VDO_LIM_C_MAX 8'hf0
`define VDO_INT_MIN 8'h01
`define VDO_INT_MAX 8'hfe
`define VDO_THR_25 8'h47
`define VDO_THR_50 8'h7e
// ----------------------------------------
// line numbers
// ----------------------------------------
`define VDO_L_FIRST 10'h001
`define VDO_L_6 10'h006
`define VDO_L_9 10'h009
`define VDO_L_19 10'h013
`define VDO_L_22 10'h016
`define VDO_L_23 10'h017
`define VDO_L_263 10'h107
`define VDO_L_264 10'h108
`define VDO_L_272 10'h110
`define VDO_L_282 10'h11a
`define VDO_L_311 10'h137
`define VDO_L_318 10'h13e
`define VDO_L_335 10'h14f
`define VDO_L_623 10'h26f
`define VDO_L_624 10'h270
`define VDO_L_625 10'h271
// ----------------------------------------
// serial port
// ----------------------------------------
`define VDO_I2C_BITS 4'h8
`endif

// ==== src/vdo_pkg.sv ====
// types shared by the video output control block
package vdo_pkg;
  typedef struct packed {
    logic mono;
    logic lines625;
    logic [1:0] colour;
    logic [1:0] subc;
  } vdo_fmt_t;

  typedef struct packed {
    logic hsync;
    logic vsync;
    logic aux;
    logic [7:0] data;
  } vdo_vid_t;

  typedef enum logic [2:0] {
    VDO_S_IDLE = 3'b000,
    VDO_S_ADDR = 3'b001,
    VDO_S_AACK = 3'b010,
    VDO_S_WR = 3'b011,
    VDO_S_WACK = 3'b100,
    VDO_S_RD = 3'b101,
    VDO_S_RACK = 3'b110
  } vdo_i2c_st_t;

  typedef enum logic [1:0] {
    VDO_V_BLACK = 2'b00,
    VDO_V_MONO = 2'b01,
    VDO_V_SLICE = 2'b10,
    VDO_V_RSVD = 2'b11
  } vdo_vdec_t;
endpackage : vdo_pkg

// ==== src/vdo_i2c_slave.sv ====
// serial register port: byte-wide sub-addressed writes and reads
`timescale 1ns/10ps
`include "vdo_defines.svh"
module vdo_i2c_slave
  import vdo_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h2a
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // serial pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_oe_n,
  // register side
  output logic wr_en,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data,
  output logic [7:0] rd_addr,
  input wire logic [7:0] rd_data
);
  if (DEV_ADDR < 7'h08) begin : g_chk
    $error("device address lies in the reserved range");
  end

  logic [2:0] scl_r;
  logic [2:0] sda_r;
  logic scl_f_q, sda_f_q, scl_p_q, sda_p_q;
  vdo_i2c_st_t st_q;
  logic [7:0] sh_q, sub_q;
  logic [3:0] cnt_q;
  logic have_sub_q, rw_q, nack_q;
  logic scl_rise, scl_fall, start, stop;

  // ----------------------------------------
  // pin sampling and filtering
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      scl_r <= 3'h7;
      sda_r <= 3'h7;
    end else begin
      scl_r <= {scl_r[1:0], scl_in};
      sda_r <= {sda_r[1:0], sda_in};
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      scl_f_q <= 1'b1;
      sda_f_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      if (scl_r[1] == scl_r[2]) scl_f_q <= scl_r[2];
      if (sda_r[1] == sda_r[2]) sda_f_q <= sda_r[2];
      scl_p_q <= scl_f_q;
      sda_p_q <= sda_f_q;
    end
  end

  assign scl_rise = scl_f_q & ~scl_p_q;
  assign scl_fall = ~scl_f_q & scl_p_q;
  assign start = scl_f_q & scl_p_q & sda_p_q & ~sda_f_q;
  assign stop = scl_f_q & scl_p_q & ~sda_p_q & sda_f_q;
  assign rd_addr = sub_q;

  // ----------------------------------------
  // protocol engine
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_q <= VDO_S_IDLE;
      sh_q <= 8'h00;
      cnt_q <= 4'h0;
      sub_q <= 8'h00;
      have_sub_q <= 1'b0;
      rw_q <= 1'b0;
      nack_q <= 1'b0;
      sda_oe_n <= 1'b1;
      wr_en <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
    end else begin
      wr_en <= 1'b0;
      if (start) begin
        st_q <= VDO_S_ADDR;
        cnt_q <= 4'h0;
        have_sub_q <= 1'b0;
        sda_oe_n <= 1'b1;
      end else if (stop) begin
        st_q <= VDO_S_IDLE;
        sda_oe_n <= 1'b1;
      end else if (scl_rise) begin
        if (st_q == VDO_S_ADDR || st_q == VDO_S_WR) begin
          sh_q <= {sh_q[6:0], sda_f_q};
          cnt_q <= cnt_q + 4'h1;
        end
        if (st_q == VDO_S_RACK) nack_q <= sda_f_q;
      end else if (scl_fall) begin
        case (st_q)
          VDO_S_IDLE: st_q <= VDO_S_IDLE;
          VDO_S_ADDR: if (cnt_q == `VDO_I2C_BITS) begin
            if (sh_q[7:1] == DEV_ADDR) begin
              st_q <= VDO_S_AACK;
              sda_oe_n <= 1'b0;
              rw_q <= sh_q[0];
            end else begin
              st_q <= VDO_S_IDLE;
            end
          end
          VDO_S_WR: if (cnt_q == `VDO_I2C_BITS) begin
            st_q <= VDO_S_WACK;
            sda_oe_n <= 1'b0;
            if (have_sub_q) begin
              wr_en <= 1'b1;
              wr_addr <= sub_q;
              wr_data <= sh_q;
              sub_q <= sub_q + 8'h01;
            end else begin
              sub_q <= sh_q;
              have_sub_q <= 1'b1;
            end
          end
          VDO_S_WACK: begin
            st_q <= VDO_S_WR;
            sda_oe_n <= 1'b1;
            cnt_q <= 4'h0;
          end
          VDO_S_AACK, VDO_S_RACK: begin
            if ((st_q == VDO_S_AACK && !rw_q) || (st_q == VDO_S_RACK && nack_q)) begin
              st_q <= (st_q == VDO_S_AACK) ? VDO_S_WR : VDO_S_IDLE;
              sda_oe_n <= 1'b1;
              cnt_q <= 4'h0;
            end else begin
              st_q <= VDO_S_RD;
              sh_q <= rd_data;
              sda_oe_n <= rd_data[7];
              cnt_q <= 4'h1;
            end
          end
          VDO_S_RD: begin
            if (cnt_q == `VDO_I2C_BITS) begin
              st_q <= VDO_S_RACK;
              sda_oe_n <= 1'b1;
              sub_q <= sub_q + 8'h01;
            end else begin
              sda_oe_n <= sh_q[6];
              sh_q <= {sh_q[6:0], 1'b0};
              cnt_q <= cnt_q + 4'h1;
            end
          end
          default: st_q <= VDO_S_IDLE;
        endcase
      end
    end
  end
endmodule : vdo_i2c_slave

// ==== sim/vdo_video_sink.sv ====
// downstream video sink model: captures the pin bundle as a receiver sees it
`timescale 1ns/10ps
module vdo_video_sink
  import vdo_pkg::*;
(
  // pins from the block
  input wire logic pixel_clock_out,
  input wire logic pins_oe_n,
  input wire vdo_vid_t vid_out,
  // captured pixel
  output vdo_vid_t seen_q,
  output logic float_q
);
  // a floated bus reads as the inverse of the last value, never as a held copy
  always @(posedge pixel_clock_out or posedge pins_oe_n) begin
    float_q <= pins_oe_n;
    seen_q <= pins_oe_n ? ~seen_q : vid_out;
  end
endmodule : vdo_video_sink

// ==== sim/tb.sv ====
// self-checking bench for the video output control block
`timescale 1ns/10ps
module tb;
  import vdo_pkg::*;
  // ----------------------------------------
  // signals and instances
  // ----------------------------------------
  localparam logic [6:0] DEV = 7'h2a;
  logic core_clk = 0, rst = 1, scl = 1, sda_m = 1, ck_en = 0, locked = 0, luma = 1, half = 0, pdn_n = 1;
  logic sda_out, sda_oe_n, pclk, oe_n, vflag, flt, p0;
  wire logic sda_in = sda_m & sda_oe_n;
  logic [7:0] pix = 8'h00;
  logic [9:0] line = 10'h064;
  vdo_fmt_t det = '0, act;
  vdo_vid_t sync = '1, vout, seen;
  int num_errors = 0, checks_done = 0;
  always #10 core_clk = ~core_clk;
  vdo_output_ctrl #(.DEV_ADDR(DEV)) i_vdo_output_ctrl (.core_clk(core_clk), .rst(rst), .scl_in(scl), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .det_fmt(det), .det_locked(locked), .colour_kill_en(ck_en),
    .active_fmt(act), .pix_code(pix), .pix_is_luma(luma), .line_num(line), .line_second_half(half),
    .sync_in(sync), .power_down_pin_n(pdn_n), .pixel_clock_out(pclk), .vid_out(vout), .vflag_out(vflag),
    .pins_oe_n(oe_n));
  vdo_video_sink i_vdo_video_sink (.pixel_clock_out(pclk), .pins_oe_n(oe_n), .vid_out(vout), .seen_q(seen),
    .float_q(flt));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic wc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : wc
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic sbit(input logic b, output logic q);
    sda_m = b;
    wc(2);
    scl = 1;
    wc(8);
    q = sda_in;
    scl = 0;
    wc(6);
  endtask : sbit
  task automatic sbyte(input logic [7:0] d, output logic [7:0] q, output logic k);
    for (int i = 7; i >= 0; i--) sbit(d[i], q[i]);
    sbit(1'b1, k);
  endtask : sbyte
  task automatic sstart();
    sda_m = 1;
    wc(2);
    scl = 1;
    wc(8);
    sda_m = 0;
    wc(8);
    scl = 0;
    wc(4);
  endtask : sstart
  task automatic sstop();
    sda_m = 0;
    wc(2);
    scl = 1;
    wc(8);
    sda_m = 1;
    wc(8);
  endtask : sstop
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic k;
    sstart();
    sbyte({DEV, 1'b0}, q, k);
    chk({7'h0, k}, 8'h00);
    sbyte(a, q, k);
    sbyte(d, q, k);
    sstop();
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] q;
    logic k;
    sstart();
    sbyte({DEV, 1'b0}, q, k);
    sbyte(a, q, k);
    sstart();
    sbyte({DEV, 1'b1}, q, k);
    sbyte(8'hff, q, k);
    sstop();
    chk(q, exp);
  endtask : rdc
  // one pixel case: control byte, line, code, sample kind, expected data and v flag
  task automatic row(input logic [7:0] r4, input int ln, input logic [7:0] px, input logic lu,
                     input logic [7:0] ex, input logic v);
    wr(8'h04, r4);
    line = ln[9:0];
    pix = px;
    luma = lu;
    wc(8);
    chk(seen.data, ex);
    chk({7'h0, vflag}, {7'h0, v});
  endtask : row
  task automatic t_reset();
    chk(vout.data, 8'h00);
    rdc(8'h05, 8'h0f);
    rdc(8'h11, 8'heb);
    rdc(8'h12, 8'h10);
    rdc(8'h40, 8'h00);
    chk({7'h0, sda_out}, 8'h00);
  endtask : t_reset
  task automatic t_table();
    wr(8'h05, 8'h00);
    row(8'h00, 100, 8'h00, 1, 8'h01, 0);
    row(8'h00, 100, 8'hff, 0, 8'hfe, 0);
    row(8'h08, 100, 8'hff, 1, 8'heb, 0);
    row(8'h08, 100, 8'hff, 0, 8'hf0, 0);
    row(8'h08, 100, 8'h00, 0, 8'h10, 0);
    row(8'h80, 9, 8'hff, 1, 8'h10, 1);
    row(8'h80, 15, 8'hff, 1, 8'heb, 0);
    row(8'h80, 15, 8'h00, 1, 8'h10, 0);
    row(8'h80, 15, 8'h60, 1, 8'heb, 0);
    row(8'h80, 15, 8'h00, 0, 8'heb, 0);
    row(8'ha0, 15, 8'h60, 1, 8'h10, 0);
    row(8'h40, 15, 8'h60, 1, 8'h60, 0);
    row(8'h00, 15, 8'h60, 0, 8'h80, 0);
    row(8'h00, 20, 8'h60, 1, 8'h60, 0);
    row(8'h01, 20, 8'h60, 1, 8'h10, 0);
    row(8'h07, 19, 8'h60, 1, 8'h60, 0);
    row(8'h10, 19, 8'h60, 1, 8'h10, 1);
    row(8'h17, 19, 8'h60, 1, 8'h60, 1);
    row(8'h10, 20, 8'h60, 1, 8'h60, 0);
    row(8'h00, 264, 8'h60, 1, 8'h10, 1);
    row(8'h00, 263, 8'h60, 1, 8'h60, 0);
    half = 1;
    row(8'h00, 263, 8'h60, 1, 8'h10, 0);
    half = 0;
  endtask : t_table
  task automatic t_range();
    line = 10'h064;
    wr(8'h08, 8'h04);
    row(8'h00, 100, 8'h00, 1, 8'h00, 0);
    row(8'h00, 100, 8'hff, 1, 8'hff, 0);
    wr(8'h08, 8'h00);
  endtask : t_range
  task automatic t_625();
    wr(8'h02, 8'h10);
    chk({2'h0, act}, 8'h10);
    row(8'h00, 22, 8'h60, 1, 8'h10, 1);
    row(8'h00, 24, 8'h60, 1, 8'h60, 0);
    row(8'h03, 26, 8'h60, 1, 8'h10, 0);
    row(8'h80, 5, 8'hff, 1, 8'h10, 1);
    row(8'h10, 624, 8'h60, 1, 8'h10, 1);
    wr(8'h02, 8'h00);
  endtask : t_625
  task automatic t_pins();
    chk({5'h0, vout.hsync, vout.vsync, vout.aux}, 8'h07);
    wr(8'h05, 8'h0f);
    wc(4);
    chk({vout.hsync, vout.vsync, vout.aux, 5'h0}, 8'h00);
    chk(seen.data, 8'h00);
    p0 = pclk;
    wc(1);
    chk({7'h0, pclk}, {7'h0, ~p0});
    wr(8'h05, 8'h1f);
    chk({6'h0, oe_n, flt}, 8'h03);
    pdn_n = 0;
    wc(8);
    chk({6'h0, oe_n, pclk}, 8'h00);
    chk(vout.data, 8'h00);
    wc(1);
    chk({7'h0, pclk}, 8'h00);
    pdn_n = 1;
    wr(8'h05, 8'h00);
  endtask : t_pins
  task automatic t_status();
    det = '{mono: 1'b1, lines625: 1'b1, colour: 2'b01, subc: 2'b11};
    locked = 1;
    wr(8'h02, 8'h80);
    rdc(8'h18, 8'h97);
    ck_en = 1;
    rdc(8'h18, 8'hb7);
    chk({2'h0, act}, 8'h37);
    wr(8'h18, 8'h00);
    rdc(8'h18, 8'hb7);
    wr(8'h02, 8'h00);
    chk({2'h0, act}, 8'h00);
    wr(8'h03, 8'h80);
    wr(8'h02, 8'h80);
    rdc(8'h18, 8'hf7);
    wr(8'h03, 8'h00);
  endtask : t_status
  task automatic give_verdict();
    if (num_errors == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  initial begin
    wc(2);
    rst = 0;
    wc(8);
    t_reset();
    t_table();
    t_range();
    t_625();
    t_pins();
    t_status();
    give_verdict();
  end
  initial begin
    repeat (60000) @(posedge core_clk);
    num_errors++;
    give_verdict();
  end
endmodule : tb
